/* File: pao_array_core.sv */
// Purpose: AND/OR array core with macrocells, signature and test access.
// Assumes: Pins and clocks are synchronous to clk and sampled as levels.
// Notes:   Programmer reaches the pattern over a simple command port.
`timescale 1ns/1ns
module pao_array_core (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [pao_pkg::N_IN-1:0] in_pins,
    input wire logic input_capture_clock,
    input wire logic common_output_clock,
    input wire logic [pao_pkg::N_OUT-1:0] io_in,
    output logic [pao_pkg::N_OUT-1:0] io_out,
    output logic [pao_pkg::N_OUT-1:0] io_oe,
    input wire logic prog_valid,
    output logic prog_ready,
    input wire pao_pkg::pao_cmd_type prog_cmd,
    input wire logic [pao_pkg::ADDR_W-1:0] prog_addr,
    input wire logic [pao_pkg::N_LIT-1:0] prog_wdata,
    output logic [pao_pkg::N_LIT-1:0] prog_rdata,
    output logic prog_done,
    output logic prog_refused
);
    // ****************************************************************
    // Declarations
    // ****************************************************************
    localparam int ROW_W = pao_pkg::N_LIT;
    localparam int CELL_W = pao_pkg::N_ROWS * ROW_W;

    logic [CELL_W-1:0] cells;
    logic [ROW_W-1:0] mem_rd;
    logic mem_clr;
    logic mem_wr;
    logic [ROW_W-1:0] mem_wdata;
    logic [pao_pkg::N_SIG-1:0] sig;
    logic [ROW_W-1:0] lits;
    logic [pao_pkg::N_PT-1:0] pt;
    logic [pao_pkg::N_SUM-1:0] st;
    logic [pao_pkg::N_CELL-1:0] cell_q;
    logic [pao_pkg::N_CELL-1:0] cell_y;
    logic [pao_pkg::N_IN-1:0] in_q;
    logic [pao_pkg::N_IO-1:0] io_q;
    logic icap_q;
    logic ock_q;
    logic icap_rise;
    logic ock_rise;
    logic [pao_pkg::POR_W-1:0] por_q;
    logic hold;
    logic secure_q;
    pao_pkg::pao_mode_type mode_q [pao_pkg::N_CELL];
    pao_pkg::pao_state_type state_q;
    logic take;
    logic row_ok;
    logic read_ok;
    logic load;
    logic [pao_pkg::ADDR_W-1:0] sum_row_q;
    logic [pao_pkg::CK_W-1:0] sum_acc_q;
    logic [pao_pkg::CK_W-1:0] row_fold;

    // Folds one pattern row into the running checksum width
    function automatic logic [pao_pkg::CK_W-1:0] fold(
        input logic [ROW_W-1:0] r
    );
        logic [5*pao_pkg::CK_W-1:0] x;
        logic [pao_pkg::CK_W-1:0] s;
        x = {(5 * pao_pkg::CK_W - ROW_W)'(0), r};
        s = '0;
        for (int i = 0; i < 5; i++) begin
            s = s + x[i*pao_pkg::CK_W +: pao_pkg::CK_W];
        end
        return s;
    endfunction

    // ****************************************************************
    // Pattern store
    // ****************************************************************
    pao_cfg_mem #(
        .ROWS(pao_pkg::N_ROWS),
        .WIDTH(ROW_W),
        .AW(pao_pkg::ADDR_W)
    ) u_mem (
        .clk(clk),
        .sys_rst(sys_rst),
        .clr(mem_clr),
        .wr_en(mem_wr),
        .wr_addr(prog_addr),
        .wr_data(mem_wdata),
        .rd_addr(prog_addr),
        .rd_data(mem_rd),
        .cells(cells)
    );

    // Signature row keeps only its user bits; the rest stay zero
    assign mem_wdata = (prog_addr == pao_pkg::ROW_SIG_A) ?
        (prog_wdata & {(ROW_W - pao_pkg::SIG_BITS)'(0),
        {pao_pkg::SIG_BITS{1'b1}}}) : prog_wdata;

    // ****************************************************************
    // Power-up hold and clock edges
    // ****************************************************************
    // Registers stay clear for the power-up reset time after release
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            por_q <= '0;
        end else if (por_q != pao_pkg::POR_CYCLES) begin
            por_q <= por_q + 1'b1;
        end
    end
    assign hold = (por_q != pao_pkg::POR_CYCLES);

    // Last level of both clock pins, for rise detection
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            icap_q <= 1'b0;
            ock_q <= 1'b0;
        end else begin
            icap_q <= input_capture_clock;
            ock_q <= common_output_clock;
        end
    end

    // Edges during the hold are dropped, as the system is to send none
    assign icap_rise = input_capture_clock & ~icap_q & ~hold;
    assign ock_rise = common_output_clock & ~ock_q & ~hold;

    // ****************************************************************
    // Input macrocells
    // ****************************************************************
    // Capture both pin groups on the input clock; preload overrides
    always_ff @(posedge clk) begin
        if (sys_rst || hold) begin
            in_q <= '0;
            io_q <= '0;
        end else if (load) begin
            in_q <= prog_wdata[pao_pkg::N_IN-1:0];
            io_q <= prog_wdata[pao_pkg::N_IN +: pao_pkg::N_IO];
        end else if (icap_rise) begin
            in_q <= in_pins;
            io_q <= io_in;
        end
    end

    // ****************************************************************
    // AND plane
    // ****************************************************************
    // Feedback is the register, which breaks any combinational loop
    assign sig = {input_capture_clock, cell_q, io_q, in_q};
    assign lits = {~sig, sig};

    // Row bit set means the literal is connected to the term
    for (genvar p = 0; p < pao_pkg::N_PT; p++) begin : g_pt
        logic [ROW_W-1:0] row;
        assign row = cells[p*ROW_W +: ROW_W];
        assign pt[p] = (row != '0) && ((row & lits) == row);
    end

    // ****************************************************************
    // OR plane
    // ****************************************************************
    // Only the shared terms can reach a sum term
    for (genvar s = 0; s < pao_pkg::N_SUM; s++) begin : g_sum
        logic [pao_pkg::N_SHARED-1:0] orow;
        assign orow = cells[(pao_pkg::ROW_OR_BASE + s)*ROW_W +:
            pao_pkg::N_SHARED];
        assign st[s] = |(orow & pt[pao_pkg::N_SHARED-1:0]);
    end

    // ****************************************************************
    // Output and buried macrocells
    // ****************************************************************
    // Cells 0 to 9 own pins; the rest are buried
    for (genvar c = 0; c < pao_pkg::N_CELL; c++) begin : g_cell
        pao_macrocell u_cell (
            .clk(clk),
            .sys_rst(sys_rst),
            .hold(hold),
            .rst_term(pt[pao_pkg::PT_RESET]),
            .mode(mode_q[c]),
            .d_term(st[c]),
            .e_term(st[pao_pkg::N_CELL + c]),
            .ock_rise(ock_rise),
            .load(load),
            .load_val(prog_wdata[pao_pkg::N_IN + pao_pkg::N_IO + c]),
            .q(cell_q[c]),
            .y(cell_y[c])
        );
    end

    // Inverting output buffer, so a cleared register drives a one
    for (genvar k = 0; k < pao_pkg::N_OUT; k++) begin : g_pin
        assign io_out[k] = ~cell_y[k];
        assign io_oe[k] = pt[pao_pkg::PT_OE_BASE + k];
    end

    // ****************************************************************
    // Programmer command port
    // ****************************************************************
    assign prog_ready = (state_q == pao_pkg::ST_IDLE);
    assign take = prog_valid && prog_ready;
    assign row_ok = (prog_addr < pao_pkg::ROWS_A);
    // Secured: only the signature row may still be read
    assign read_ok = row_ok &&
        (!secure_q || prog_addr == pao_pkg::ROW_SIG_A);
    assign mem_clr = take && prog_cmd == pao_pkg::CMD_ERASE;
    assign mem_wr = take && prog_cmd == pao_pkg::CMD_WRITE && row_ok;
    assign load = take && prog_cmd == pao_pkg::CMD_PRELOAD;
    assign row_fold = fold(cells[sum_row_q*ROW_W +: ROW_W]);

    // Security cell is set by command and cleared by bulk erase alone
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            secure_q <= 1'b0;
        end else if (mem_clr) begin
            secure_q <= 1'b0;
        end else if (take && prog_cmd == pao_pkg::CMD_SECURE) begin
            secure_q <= 1'b1;
        end
    end

    // Macrocell modes; erased codes fall back to combinational use
    for (genvar m = 0; m < pao_pkg::N_CELL; m++) begin : g_mode
        always_ff @(posedge clk) begin
            if (sys_rst || mem_clr) begin
                mode_q[m] <= pao_pkg::pao_mode_type'(3'h0);
            end else if (take && prog_cmd == pao_pkg::CMD_MODE) begin
                mode_q[m] <= pao_pkg::pao_mode_type'(prog_wdata[3*m +: 3]);
            end
        end
    end

    // Sequencer for reads and the checksum walk
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= pao_pkg::ST_IDLE;
        end else begin
            unique case (state_q)
                pao_pkg::ST_IDLE: begin
                    if (take && prog_cmd == pao_pkg::CMD_READ && read_ok) begin
                        state_q <= pao_pkg::ST_READ;
                    end else if (take && prog_cmd == pao_pkg::CMD_CHECKSUM) begin
                        state_q <= pao_pkg::ST_SUM;
                    end
                end
                pao_pkg::ST_READ: state_q <= pao_pkg::ST_IDLE;
                pao_pkg::ST_SUM: begin
                    if (sum_row_q == pao_pkg::ROW_SIG_A) begin
                        state_q <= pao_pkg::ST_IDLE;
                    end
                end
                default: state_q <= pao_pkg::ST_IDLE;
            endcase
        end
    end

    // Checksum walks every row, the signature row last
    always_ff @(posedge clk) begin
        if (sys_rst || state_q != pao_pkg::ST_SUM) begin
            sum_row_q <= '0;
            sum_acc_q <= '0;
        end else begin
            sum_row_q <= sum_row_q + 1'b1;
            sum_acc_q <= sum_acc_q + row_fold;
        end
    end

    // Answer strobes: one-cycle pulses, one cycle after the work ends
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prog_done <= 1'b0;
            prog_refused <= 1'b0;
        end else begin
            prog_done <= (state_q == pao_pkg::ST_READ) ||
                (state_q == pao_pkg::ST_SUM && sum_row_q == pao_pkg::ROW_SIG_A) ||
                (take && (prog_cmd == pao_pkg::CMD_ERASE ||
                prog_cmd == pao_pkg::CMD_SECURE ||
                prog_cmd == pao_pkg::CMD_PRELOAD ||
                prog_cmd == pao_pkg::CMD_DIAG ||
                prog_cmd == pao_pkg::CMD_MODE ||
                (prog_cmd == pao_pkg::CMD_WRITE && row_ok)));
            prog_refused <= take && ((prog_cmd == pao_pkg::CMD_READ && !read_ok) ||
                (prog_cmd == pao_pkg::CMD_WRITE && !row_ok) ||
                prog_cmd > pao_pkg::CMD_CHECKSUM);
        end
    end

    // Read data: pattern row, register snapshot or checksum
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prog_rdata <= '0;
        end else if (state_q == pao_pkg::ST_READ) begin
            prog_rdata <= mem_rd;
        end else if (state_q == pao_pkg::ST_SUM && sum_row_q == pao_pkg::ROW_SIG_A) begin
            prog_rdata <= {(ROW_W - pao_pkg::CK_W)'(0), sum_acc_q + row_fold};
        end else if (take && prog_cmd == pao_pkg::CMD_DIAG) begin
            prog_rdata <= {(ROW_W - pao_pkg::REG_BITS)'(0), cell_q, io_q, in_q};
        end
    end
endmodule

/* File: pao_pkg.sv */
// Purpose: Shared constants and types for the AND/OR array core.
// Assumes: One 50 MHz system clock; all pins synchronous to it.
// Notes:   Row map: AND rows, then D sum rows, E sum rows, signature.
package pao_pkg;
    // ****************************************************************
    // Array geometry
    // ****************************************************************
    localparam int N_IN = 10;
    localparam int N_IO = 10;
    localparam int N_OUT = 10;
    localparam int N_BUR = 8;
    localparam int N_CELL = N_OUT + N_BUR;
    localparam int N_SIG = N_IN + N_IO + N_BUR + N_OUT + 1;
    localparam int N_LIT = 2 * N_SIG;
    localparam int N_PT = 75;
    localparam int N_SHARED = 64;
    localparam int PT_RESET = 64;
    localparam int PT_OE_BASE = 65;
    localparam int N_SUM = 2 * N_CELL;
    localparam int ROW_OR_BASE = N_PT;
    localparam int ROW_SIG = ROW_OR_BASE + N_SUM;
    localparam int N_ROWS = ROW_SIG + 1;
    localparam int SIG_BITS = 72;
    localparam int ADDR_W = 7;
    localparam int CK_W = 16;
    localparam int REG_BITS = N_IN + N_IO + N_CELL;
    localparam logic [ADDR_W-1:0] ROW_SIG_A = ADDR_W'(ROW_SIG);
    localparam logic [ADDR_W-1:0] ROWS_A = ADDR_W'(N_ROWS);

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 20;
    localparam int POWER_UP_RESET_TIME_NS = 1000;
    localparam int POR_W = 6;
    localparam logic [POR_W-1:0] POR_CYCLES =
        POR_W'(POWER_UP_RESET_TIME_NS / CLK_PERIOD_NS);

    // ****************************************************************
    // Modes, commands, states
    // ****************************************************************
    typedef enum logic [2:0] {
        MODE_COMB = 3'h1,
        MODE_DE = 3'h2,
        MODE_STCLK = 3'h4
    } pao_mode_type;

    typedef enum logic [3:0] {
        CMD_ERASE = 4'h0,
        CMD_WRITE = 4'h1,
        CMD_READ = 4'h2,
        CMD_SECURE = 4'h3,
        CMD_PRELOAD = 4'h4,
        CMD_DIAG = 4'h5,
        CMD_MODE = 4'h6,
        CMD_CHECKSUM = 4'h7
    } pao_cmd_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_READ = 3'h2,
        ST_SUM = 3'h4
    } pao_state_type;
endpackage

/* File: pao_cfg_mem.sv */
// Purpose: Pattern store for both planes and the signature row.
// Assumes: Whole pattern is also needed in parallel by the planes.
// Notes:   Read data comes out of a register, one cycle after address.
`timescale 1ns/1ns
module pao_cfg_mem #(
    parameter int ROWS = 112,
    parameter int WIDTH = 78,
    parameter int AW = 7
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clr,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data,
    output logic [ROWS*WIDTH-1:0] cells
);
    logic [WIDTH-1:0] mem_q [ROWS];

    // One row per entry; erase wipes every row at once
    for (genvar r = 0; r < ROWS; r++) begin : g_row
        always_ff @(posedge clk) begin
            if (sys_rst || clr) begin
                mem_q[r] <= '0;
            end else if (wr_en && wr_addr == AW'(r)) begin
                mem_q[r] <= wr_data;
            end
        end
        assign cells[r*WIDTH +: WIDTH] = mem_q[r];
    end

    // Registered read port; out-of-range rows read as zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_data <= '0;
        end else if (rd_addr < AW'(ROWS)) begin
            rd_data <= mem_q[rd_addr];
        end else begin
            rd_data <= '0;
        end
    end
endmodule

/* File: pao_macrocell.sv */
// Purpose: One output or buried macrocell register with its clocking.
// Assumes: Clock edges arrive as one-cycle rise pulses or level terms.
// Notes:   Sum-term clock is an edge detected on the system clock.
`timescale 1ns/1ns
module pao_macrocell (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic hold,
    input wire logic rst_term,
    input wire pao_pkg::pao_mode_type mode,
    input wire logic d_term,
    input wire logic e_term,
    input wire logic ock_rise,
    input wire logic load,
    input wire logic load_val,
    output logic q,
    output logic y
);
    logic e_q;
    logic q_q;

    // Previous enable/clock term for edge detection
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            e_q <= 1'b0;
        end else begin
            e_q <= e_term;
        end
    end

    // Register; preload beats the reset term so tests can force states
    always_ff @(posedge clk) begin
        if (sys_rst || hold) begin
            q_q <= 1'b0;
        end else if (load) begin
            q_q <= load_val;
        end else if (rst_term) begin
            q_q <= 1'b0;
        end else begin
            unique case (mode)
                pao_pkg::MODE_DE: begin
                    if (ock_rise && e_term) begin
                        q_q <= d_term;
                    end
                end
                pao_pkg::MODE_STCLK: begin
                    if (e_term && !e_q) begin
                        q_q <= d_term;
                    end
                end
                pao_pkg::MODE_COMB: q_q <= d_term;
                default: q_q <= d_term;
            endcase
        end
    end

    // In the two registered modes the reset term clears the visible value at once, not at the next edge
    assign q = q_q;
    assign y = (mode == pao_pkg::MODE_DE || mode == pao_pkg::MODE_STCLK) ?
        (q_q & ~rst_term) : d_term;
endmodule

/* File: pao_array_core_chk.sv */
// Purpose: Port assertions for the AND/OR array core.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Security state is mirrored from the command stream.
`timescale 1ns/1ns
module pao_array_core_chk (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [pao_pkg::N_OUT-1:0] io_out,
    input wire logic [pao_pkg::N_OUT-1:0] io_oe,
    input wire logic prog_valid,
    input wire logic prog_ready,
    input wire pao_pkg::pao_cmd_type prog_cmd,
    input wire logic [pao_pkg::ADDR_W-1:0] prog_addr,
    input wire logic prog_done,
    input wire logic prog_refused
);
    logic take;
    logic rd_plane;
    logic secured_q;
    // Accepted request, and plane reads with the signature row left out
    assign take = prog_valid && prog_ready;
    assign rd_plane = take && prog_cmd == pao_pkg::CMD_READ && prog_addr < pao_pkg::ROW_SIG_A;
    // Mirror of the security cell; only erase clears it
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            secured_q <= 1'b0;
        end else if (take && prog_cmd == pao_pkg::CMD_SECURE) begin
            secured_q <= 1'b1;
        end else if (take && prog_cmd == pao_pkg::CMD_ERASE) begin
            secured_q <= 1'b0;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    a_reset_blank_oe: assert property (
        disable iff (1'b0) sys_rst |=> io_oe == '0 && prog_ready)
        else $error("enables or ready wrong after reset");
    a_hold_pins_high: assert property (
        $fell(sys_rst) |-> (io_out == '1)[*8])
        else $error("pins not high after reset release");
    a_sig_read_open: assert property (
        take && prog_cmd == pao_pkg::CMD_READ && prog_addr == pao_pkg::ROW_SIG_A
        |=> !prog_ready ##1 (prog_done && !prog_refused))
        else $error("signature read not answered");
    a_row_range_refuse: assert property (
        take && prog_cmd == pao_pkg::CMD_READ && prog_addr >= pao_pkg::ROWS_A
        |-> ##[1:2] prog_refused)
        else $error("read beyond last row not refused");
    a_simple_cmd_done: assert property (
        take && prog_cmd inside {pao_pkg::CMD_ERASE, pao_pkg::CMD_SECURE, pao_pkg::CMD_PRELOAD,
        pao_pkg::CMD_DIAG, pao_pkg::CMD_MODE, pao_pkg::CMD_WRITE} && prog_addr < pao_pkg::ROWS_A
        |=> prog_done && !prog_refused)
        else $error("single-cycle command not done");
    a_checksum_time: assert property (
        take && prog_cmd == pao_pkg::CMD_CHECKSUM |=> (!prog_ready)[*8] ##105 prog_done)
        else $error("checksum timing wrong");
    a_secure_refuse: assert property (
        rd_plane && secured_q |=> prog_refused && !prog_done)
        else $error("secured plane read not refused");
    a_erase_unlock: assert property (
        rd_plane && !secured_q |=> !prog_refused ##1 prog_done)
        else $error("open plane read not answered");
endmodule
bind pao_array_core pao_array_core_chk chk_u (
    .clk(clk), .sys_rst(sys_rst), .io_out(io_out), .io_oe(io_oe), .prog_valid(prog_valid),
    .prog_ready(prog_ready), .prog_cmd(prog_cmd), .prog_addr(prog_addr),
    .prog_done(prog_done), .prog_refused(prog_refused)
);

/* File: pao_prog_model.sv */
// Purpose: Programmer model driving the command port of the array core.
// Assumes: Requests launch at the falling edge and wait for ready.
// Notes:   Released lines show inverted data so stale values never match.
`timescale 1ns/1ns
module pao_prog_model (
    input wire logic clk,
    input wire logic prog_ready,
    output logic prog_valid,
    output pao_pkg::pao_cmd_type prog_cmd,
    output logic [pao_pkg::ADDR_W-1:0] prog_addr,
    output logic [pao_pkg::N_LIT-1:0] prog_wdata
);
    int stall = 0;
    // Idle bus at time zero
    initial begin
        prog_valid = 1'b0;
        prog_cmd = pao_pkg::CMD_READ;
        prog_addr = '0;
        prog_wdata = '0;
    end
    // One request, held until taken, then released; stall makes a slow programmer
    task automatic issue(input pao_pkg::pao_cmd_type c, input logic [pao_pkg::ADDR_W-1:0] a,
            input logic [pao_pkg::N_LIT-1:0] d);
        int n;
        n = 0;
        repeat (stall) @(negedge clk);
        @(negedge clk);
        prog_valid = 1'b1;
        prog_cmd = c;
        prog_addr = a;
        prog_wdata = d;
        @(posedge clk);
        while (prog_ready !== 1'b1 && n < 300) begin
            n++;
            @(posedge clk);
        end
        @(negedge clk);
        prog_valid = 1'b0;
        prog_addr = ~prog_addr;
        prog_wdata = ~prog_wdata;
    endtask
endmodule

/* File: pao_array_core_bench.sv */
// Purpose: Self-checking bench for the AND/OR array core.
// Assumes: Programmer model drives the command port; bench drives pins.
// Notes:   Expected answers queue in issue order and pop as they appear.
`timescale 1ns/1ns
module pao_array_core_bench;
    typedef struct {
        logic rf;
        logic [pao_pkg::N_LIT-1:0] mask;
        logic [pao_pkg::N_LIT-1:0] val;
    } pao_exp_type;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [pao_pkg::N_IN-1:0] in_pins = '0;
    logic input_capture_clock = 1'b0; // Static clocks keep captures out
    logic common_output_clock = 1'b0;
    logic [pao_pkg::N_OUT-1:0] io_in = '0;
    logic [pao_pkg::N_OUT-1:0] io_out;
    logic [pao_pkg::N_OUT-1:0] io_oe;
    logic prog_valid;
    logic prog_ready;
    pao_pkg::pao_cmd_type prog_cmd;
    logic [pao_pkg::ADDR_W-1:0] prog_addr;
    logic [pao_pkg::N_LIT-1:0] prog_wdata;
    logic [pao_pkg::N_LIT-1:0] prog_rdata;
    logic prog_done;
    logic prog_refused;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;
    pao_exp_type exp_q[$];
    pao_exp_type e;
    logic [71:0] sig;
    logic [pao_pkg::N_LIT-1:0] row;
    // 50 MHz clock
    always #10 clk = ~clk;
    pao_array_core dut_u (
        .clk(clk), .sys_rst(sys_rst), .in_pins(in_pins),
        .input_capture_clock(input_capture_clock), .common_output_clock(common_output_clock),
        .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .prog_valid(prog_valid),
        .prog_ready(prog_ready), .prog_cmd(prog_cmd), .prog_addr(prog_addr),
        .prog_wdata(prog_wdata), .prog_rdata(prog_rdata), .prog_done(prog_done),
        .prog_refused(prog_refused)
    );
    pao_prog_model prog_u (
        .clk(clk), .prog_ready(prog_ready), .prog_valid(prog_valid), .prog_cmd(prog_cmd),
        .prog_addr(prog_addr), .prog_wdata(prog_wdata)
    );
    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [pao_pkg::N_LIT-1:0] seen,
            input logic [pao_pkg::N_LIT-1:0] want);
        compares++;
        if (seen !== want) begin
            num_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    // Note the answer first, so the monitor never sees it before its note
    task automatic send(input pao_pkg::pao_cmd_type c, input int a,
            input logic [pao_pkg::N_LIT-1:0] d, input logic rf,
            input logic [pao_pkg::N_LIT-1:0] m, input logic [pao_pkg::N_LIT-1:0] v);
        exp_q.push_back('{rf, m, v});
        prog_u.stall = $urandom_range(2, 0);
        prog_u.issue(c, pao_pkg::ADDR_W'(a), d);
    endtask
    // Bounded wait until every noted answer has arrived
    task automatic settle();
        int n;
        n = 0;
        while ((exp_q.size() != 0 || prog_ready !== 1'b1) && n < 300) begin
            n++;
            @(negedge clk);
        end
        @(negedge clk);
    endtask
    // Checksum model: 16-bit chunk sums of the only non-blank row
    function automatic logic [15:0] fold(input logic [pao_pkg::N_LIT-1:0] r);
        logic [15:0] s;
        s = 16'h0000;
        for (int i = 0; i < 5; i++) s = s + 16'(r >> (16 * i));
        return s;
    endfunction
    // Each answer is matched to the oldest note
    always @(negedge clk) begin
        if (!sys_rst && (prog_done === 1'b1 || prog_refused === 1'b1)) begin
            if (exp_q.size() == 0) begin
                check(1'b1, 1'b0);
            end else begin
                e = exp_q.pop_front();
                check(prog_refused, e.rf);
                check(prog_rdata & e.mask, e.val);
            end
        end
    end
    // Pins wander randomly; idle capture clock means they must not matter
    always @(negedge clk) begin
        in_pins <= pao_pkg::N_IN'($urandom);
        io_in <= pao_pkg::N_OUT'($urandom);
    end
    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            num_errors++;
            $display("MISMATCH at %0t: run did not finish", $time);
            final_report();
        end
    end
    // Main sequence
    initial begin
        void'($urandom(32'h0DE7FD8F));
        sig = {$urandom, $urandom, 8'($urandom)};
        repeat (6) @(negedge clk);
        sys_rst = 1'b0;
        repeat (pao_pkg::POR_CYCLES + 4) @(negedge clk);
        check(io_oe, 10'h000);
        check(io_out, 10'h3FF);
        $display("test power-up done");
        send(pao_pkg::CMD_WRITE, pao_pkg::PT_OE_BASE, 78'h80_0000_0000, 1'b0, '0, '0);
        settle();
        check(io_oe, 10'h001);
        send(pao_pkg::CMD_MODE, 0, 78'h2, 1'b0, '0, '0);
        send(pao_pkg::CMD_PRELOAD, 0, 78'h10_0001, 1'b0, '0, '0);
        settle();
        check(io_oe, 10'h000);
        check(io_out[0], 1'b0);
        send(pao_pkg::CMD_DIAG, 0, '0, 1'b0, 78'h3F_FFFF_FFFF, 78'h10_0001);
        send(pao_pkg::CMD_WRITE, pao_pkg::PT_RESET, 78'h1, 1'b0, '0, '0);
        settle();
        check(io_out[0], 1'b1);
        send(pao_pkg::CMD_DIAG, 0, '0, 1'b0, 78'h3F_FFFF_FFFF, 78'h1);
        settle();
        $display("test macrocells done");
        send(pao_pkg::CMD_ERASE, 0, '0, 1'b0, '0, '0);
        send(pao_pkg::CMD_WRITE, pao_pkg::ROW_SIG, {6'h00, sig}, 1'b0, '0, '0);
        send(pao_pkg::CMD_READ, pao_pkg::ROW_SIG, '0, 1'b0, '1, {6'h00, sig});
        send(pao_pkg::CMD_CHECKSUM, 0, '0, 1'b0, 78'hFFFF, 78'(fold({6'h00, sig})));
        send(pao_pkg::CMD_SECURE, 0, '0, 1'b0, '0, '0);
        send(pao_pkg::CMD_READ, 0, '0, 1'b1, '0, '0);
        send(pao_pkg::CMD_READ, pao_pkg::ROW_SIG, '0, 1'b0, '1, {6'h00, sig});
        send(pao_pkg::CMD_READ, pao_pkg::N_ROWS, '0, 1'b1, '0, '0);
        send(pao_pkg::pao_cmd_type'(4'hF), 0, '0, 1'b1, '0, '0);
        send(pao_pkg::CMD_ERASE, 0, '0, 1'b0, '0, '0);
        row = 78'({$urandom, $urandom, $urandom});
        send(pao_pkg::CMD_WRITE, 3, row, 1'b0, '0, '0);
        send(pao_pkg::CMD_READ, 3, '0, 1'b0, '1, row);
        send(pao_pkg::CMD_READ, 0, '0, 1'b0, '1, '0);
        settle();
        $display("test security done");
        // Cell 0 sum-term clocked, cell 1 clock-enabled; both terms follow the capture clock
        send(pao_pkg::CMD_ERASE, 0, '0, 1'b0, '0, '0);
        send(pao_pkg::CMD_MODE, 0, 78'h14, 1'b0, '0, '0);
        send(pao_pkg::CMD_WRITE, 0, 78'h40_0000_0000, 1'b0, '0, '0);
        for (int i = 0; i < 2; i++) begin
            send(pao_pkg::CMD_WRITE, pao_pkg::ROW_OR_BASE + i, 78'h1, 1'b0, '0, '0);
            send(pao_pkg::CMD_WRITE, pao_pkg::ROW_SIG - pao_pkg::N_CELL + i, 78'h1, 1'b0, '0,
                '0);
        end
        settle();
        check(io_out[1:0], 2'b11);
        input_capture_clock = 1'b1;
        repeat (2) @(negedge clk);
        common_output_clock = 1'b1;
        repeat (2) @(negedge clk);
        input_capture_clock = 1'b0;
        common_output_clock = 1'b0;
        repeat (2) @(negedge clk);
        check(io_out[1:0], 2'b00);
        $display("test clocking done");
        final_report();
    end
endmodule
